/* File: rtl/pslt_pkg.sv */
`default_nettype none

package pslt_pkg;

    // ==========================================================
    // register map (byte offsets from the function's memory base)
    // ==========================================================
    localparam logic [7:0]  PSLT_BAR_CFG_OFFSET   = 8'h10;
    localparam logic [7:0]  PSLT_PERIODIC_START   = 8'h40;
    localparam logic [7:0]  PSLT_LOWSPEED_THRESH  = 8'h44;

    // ==========================================================
    // field layout and reset values
    // ==========================================================
    localparam int          PSLT_FR_W             = 14;
    localparam int          PSLT_LST_W            = 12;
    localparam logic [13:0] PSLT_PS_RESET         = 14'h0000;
    localparam logic [11:0] PSLT_LST_RESET        = 12'h0628;

    // ==========================================================
    // register access port
    // ==========================================================
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } pslt_req_t;

    typedef struct packed {
        logic        hit;
        logic [31:0] rdata;
    } pslt_rsp_t;

    // scheduler view of the frame
    typedef enum logic [1:0] {
        PSLT_NONPERIODIC = 2'b00,
        PSLT_DRAIN       = 2'b01,
        PSLT_PERIODIC    = 2'b10
    } pslt_phase_t;

endpackage : pslt_pkg

`default_nettype wire

/* File: rtl/pslt_frame_counter.sv */
`timescale 1ns/10ps
`default_nettype none

module pslt_frame_counter
    import pslt_pkg::*;
(
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rstn_i,
    // bit-time pacing
    input  wire logic                 bit_time_i,
    input  wire logic [13:0]          frame_interval_value_i,
    // count
    output logic [13:0]               frame_remaining_count_o,
    output logic                      frame_start_o
);

    typedef struct packed {
        logic [13:0] cnt;
        logic        sof;
    } pslt_fc_state_t;

    pslt_fc_state_t state_reg;
    pslt_fc_state_t state_next;

    // ==========================================================
    // down counter with reload
    // ==========================================================
    always_comb
    begin
        state_next     = state_reg;
        state_next.sof = 1'b0;
        if (bit_time_i)
        begin
            if (state_reg.cnt == 14'h0000)
            begin
                state_next.cnt = frame_interval_value_i;
                state_next.sof = 1'b1;
            end
            else
            begin
                state_next.cnt = state_reg.cnt - 14'h0001;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign frame_remaining_count_o = state_reg.cnt;
    assign frame_start_o           = state_reg.sof;

    reload_zero_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (bit_time_i && state_reg.cnt == 14'h0000) |=> state_reg.cnt == $past(frame_interval_value_i))
        else $error("frame counter did not reload at zero");

    decrement_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (bit_time_i && state_reg.cnt != 14'h0000) |=> state_reg.cnt == $past(state_reg.cnt) - 14'h0001)
        else $error("frame counter did not decrement");

endmodule : pslt_frame_counter

`default_nettype wire

/* File: rtl/pslt_core.sv */
`timescale 1ns/10ps
`default_nettype none

module pslt_core
    import pslt_pkg::*;
(
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rstn_i,
    // register access
    input  wire pslt_pkg::pslt_req_t  req_i,
    output pslt_pkg::pslt_rsp_t       rsp_o,
    // frame timing
    input  wire logic                 bit_time_i,
    input  wire logic [13:0]          frame_interval_value_i,
    output logic [13:0]               frame_remaining_count_o,
    // scheduler
    input  wire logic                 async_busy_i,
    input  wire logic                 ls_request_i,
    output logic                      periodic_priority_o,
    output logic                      interrupt_list_go_o,
    output logic                      ls_start_o,
    output logic                      ls_refused_o
);
    import pslt_pkg::*;

    typedef struct packed {
        logic [13:0]  ps;
        logic [11:0]  lowspeed_commit_threshold;
        pslt_phase_t  phase;
        logic         int_go;
        logic         ls_go;
        logic         ls_no;
        pslt_rsp_t    rsp;
    } pslt_state_t;

    pslt_state_t state_reg;
    pslt_state_t state_next;
    logic [13:0] fr;
    logic        sof;

    function automatic logic ls_fits(input logic [13:0] rem, input logic [11:0] thr);
        ls_fits = rem >= {2'b00, thr};
    endfunction : ls_fits

    pslt_frame_counter u_frame
    (
        .clk_i                   (clk_i),
        .rstn_i                  (rstn_i),
        .bit_time_i              (bit_time_i),
        .frame_interval_value_i  (frame_interval_value_i),
        .frame_remaining_count_o (fr),
        .frame_start_o           (sof)
    );

    // ==========================================================
    // registers and scheduling
    // ==========================================================
    always_comb
    begin
        state_next        = state_reg;
        state_next.int_go = 1'b0;
        state_next.ls_go  = 1'b0;
        state_next.ls_no  = 1'b0;
        state_next.rsp    = '0;
        // reserved bits are simply not stored, so they read back zero
        unique case (req_i.addr)
            PSLT_PERIODIC_START:
            begin
                state_next.rsp.hit = req_i.rd | req_i.wr;
                if (req_i.wr)
                    state_next.ps = req_i.wdata[13:0];
                if (req_i.rd)
                    state_next.rsp.rdata = {18'h0_0000, state_reg.ps};
            end
            PSLT_LOWSPEED_THRESH:
            begin
                state_next.rsp.hit = req_i.rd | req_i.wr;
                if (req_i.wr)
                    state_next.lowspeed_commit_threshold = req_i.wdata[11:0];
                if (req_i.rd)
                    state_next.rsp.rdata = {20'h0_0000, state_reg.lowspeed_commit_threshold};
            end
            default:
            begin
                state_next.rsp = '0;
            end
        endcase
        unique case (state_reg.phase)
            PSLT_NONPERIODIC:
            begin
                if (fr == state_reg.ps && !sof)
                    state_next.phase = PSLT_DRAIN;
            end
            PSLT_DRAIN:
            begin
                // a transfer in flight is never cut short
                if (!async_busy_i)
                begin
                    state_next.phase  = PSLT_PERIODIC;
                    state_next.int_go = 1'b1;
                end
            end
            PSLT_PERIODIC:
            begin
                if (sof)
                    state_next.phase = PSLT_NONPERIODIC;
            end
            default:
            begin
                state_next.phase = PSLT_NONPERIODIC;
            end
        endcase
        if (ls_request_i)
        begin
            state_next.ls_go = ls_fits(fr, state_reg.lowspeed_commit_threshold);
            state_next.ls_no = !ls_fits(fr, state_reg.lowspeed_commit_threshold);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            state_reg       <= '0;
            state_reg.ps    <= PSLT_PS_RESET;
            state_reg.lowspeed_commit_threshold   <= PSLT_LST_RESET;
            state_reg.phase <= PSLT_NONPERIODIC;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign rsp_o                   = state_reg.rsp;
    assign frame_remaining_count_o = fr;
    assign periodic_priority_o     = state_reg.phase != PSLT_NONPERIODIC;
    assign interrupt_list_go_o     = state_reg.int_go;
    assign ls_start_o              = state_reg.ls_go;
    assign ls_refused_o            = state_reg.ls_no;

    // ==========================================================
    // checks
    // ==========================================================
    ps_reset_a: assert property (@(posedge clk_i) !rstn_i |=> state_reg.ps == PSLT_PS_RESET)
        else $error("periodic start not cleared by reset");

    ps_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (req_i.wr && req_i.addr == PSLT_PERIODIC_START) |=> state_reg.ps == $past(req_i.wdata[13:0]))
        else $error("periodic start write lost");

    prio_enter_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_reg.phase == PSLT_NONPERIODIC && fr == state_reg.ps && !sof) |=> periodic_priority_o)
        else $error("periodic priority not raised");

    no_abort_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_reg.phase == PSLT_DRAIN && async_busy_i) |=> !interrupt_list_go_o)
        else $error("interrupt list started during busy transfer");

    drain_done_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_reg.phase == PSLT_DRAIN && !async_busy_i) |=> interrupt_list_go_o ##1 !interrupt_list_go_o)
        else $error("interrupt list not started after transfer");

    ls_gate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ls_start_o |-> $past(ls_request_i) && $past(fr) >= {2'b00, $past(state_reg.lowspeed_commit_threshold)})
        else $error("low-speed started below threshold");

    ls_answer_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ls_request_i |=> (ls_start_o ^ ls_refused_o))
        else $error("low-speed request not answered");

    rd_reserved_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (req_i.rd && req_i.addr == PSLT_LOWSPEED_THRESH) |=> rsp_o.hit && rsp_o.rdata[31:12] == 20'h0_0000)
        else $error("threshold read wrong");

    ps_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (req_i.rd && req_i.addr == PSLT_PERIODIC_START) |=> rsp_o.rdata == {18'h0_0000, $past(state_reg.ps)})
        else $error("periodic start read wrong");

    lst_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (req_i.wr && req_i.addr == PSLT_LOWSPEED_THRESH) |=> state_reg.lowspeed_commit_threshold == $past(req_i.wdata[11:0]))
        else $error("threshold write lost");

    ls_refuse_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ls_refused_o |-> $past(ls_request_i) && $past(fr) < {2'b00, $past(state_reg.lowspeed_commit_threshold)})
        else $error("low-speed refused above threshold");

    // priority must survive a busy drain, only the frame start ends it
    prio_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (periodic_priority_o && !sof) |=> periodic_priority_o)
        else $error("periodic priority dropped inside frame");

    prio_drop_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_reg.phase == PSLT_PERIODIC && sof) |=> !periodic_priority_o)
        else $error("periodic priority kept past frame start");

    go_drain_only_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state_reg.phase != PSLT_DRAIN) |=> !interrupt_list_go_o)
        else $error("interrupt list started outside drain");

    rsp_idle_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (!req_i.rd && !req_i.wr) |=> rsp_o == '0)
        else $error("response without access");

    miss_zero_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (req_i.addr != PSLT_PERIODIC_START && req_i.addr != PSLT_LOWSPEED_THRESH) |=> rsp_o == '0)
        else $error("unmapped offset answered");

endmodule : pslt_core

`default_nettype wire

/* File: sim/periodic_start_ls_threshold_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module periodic_start_ls_threshold_tb;
    import pslt_pkg::*;

    // ==========================================================
    // signals
    // ==========================================================
    // short frame keeps the run small but still lets fr exceed 12 bits
    localparam logic [13:0] FI_VAL = 14'h1010;
    logic        clk_i, rstn_i, bit_time_i, async_busy_i, ls_request_i, run_en;
    logic        periodic_priority_o, interrupt_list_go_o, ls_start_o, ls_refused_o;
    logic        ls_pend, ls_exp, busy_q, busy_q2;
    logic [13:0] frame_remaining_count_o, exp_fr, ps_val, fi_val;
    logic [11:0] lst_val;
    pslt_req_t   req_i;
    pslt_rsp_t   rsp_o;
    int          num_errors, total_checks, go_cnt, reloads, target;
    integer      seed;

    pslt_core uut (
        .clk_i                  (clk_i),
        .rstn_i                 (rstn_i),
        .req_i                  (req_i),
        .rsp_o                  (rsp_o),
        .bit_time_i             (bit_time_i),
        .frame_interval_value_i (fi_val),
        .frame_remaining_count_o(frame_remaining_count_o),
        .async_busy_i           (async_busy_i),
        .ls_request_i           (ls_request_i),
        .periodic_priority_o    (periodic_priority_o),
        .interrupt_list_go_o    (interrupt_list_go_o),
        .ls_start_o             (ls_start_o),
        .ls_refused_o           (ls_refused_o)
    );

    // ==========================================================
    // checking and closing
    // ==========================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out

    task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                       input logic hit, input logic [31:0] rd);
        @(posedge clk_i);
        req_i <= '{wr: wr, rd: !wr, addr: addr, wdata: data};
        @(posedge clk_i);
        req_i <= '0;
        @(negedge clk_i);
        check({31'h0, rsp_o.hit}, {31'h0, hit});
        check(rsp_o.rdata, rd);
    endtask : bus

    // ==========================================================
    // frame model and stimulus, both on the rising edge
    // ==========================================================
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            exp_fr = 14'h0000;
            ls_pend = 1'b0;
            go_cnt = 0;
            reloads = 0;
        end
        else
        begin
            ls_pend = ls_request_i;
            ls_exp = ({2'b00, lst_val} <= exp_fr);
            busy_q2 = busy_q;
            busy_q = async_busy_i;
            if (interrupt_list_go_o)
                go_cnt++;
            if (bit_time_i)
            begin
                if (exp_fr == 14'h0000)
                begin
                    if (reloads > 0)
                        check(32'(go_cnt), 32'h0000_0001);
                    reloads++;
                    go_cnt = 0;
                    exp_fr = fi_val;
                end
                else
                    exp_fr = exp_fr - 14'h0001;
            end
        end
        bit_time_i <= run_en && !(exp_fr == 14'h0000 && reloads >= target);
        // requests land on fr == threshold as well as at random
        ls_request_i <= run_en && ((($random(seed) & 7) == 0) || exp_fr == {2'b00, lst_val});
        async_busy_i <= run_en && (exp_fr >= ps_val - 14'h0005 || exp_fr == 14'h0000) && 1'($random(seed));
        // reload value differs per frame, so a reload from a stale source shows up
        fi_val <= FI_VAL + 14'(target);
    end

    always @(negedge clk_i)
    begin
        if (rstn_i)
        begin
            check({18'h0, frame_remaining_count_o}, {18'h0, exp_fr});
            if (ls_pend)
            begin
                check({31'h0, ls_start_o}, {31'h0, ls_exp});
                check({31'h0, ls_refused_o}, {31'h0, !ls_exp});
            end
            else
                check({31'h0, ls_start_o | ls_refused_o}, 32'h0000_0000);
            if (exp_fr != 14'h0000 && exp_fr < ps_val)
                check({31'h0, periodic_priority_o}, 32'h0000_0001);
            if (exp_fr > ps_val && exp_fr < fi_val)
                check({31'h0, periodic_priority_o}, 32'h0000_0000);
            if (busy_q && busy_q2)
                check({31'h0, interrupt_list_go_o}, 32'h0000_0000);
        end
    end

    // ==========================================================
    // main sequence
    // ==========================================================
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    initial
    begin
        #(60000 * 4);
        num_errors++;
        close_out();
    end

    initial
    begin
        seed = 32'h4420;
        rstn_i = 1'b0;
        req_i = '0;
        run_en = 1'b0;
        target = 0;
        ps_val = 14'h0000;
        lst_val = PSLT_LST_RESET;
        bit_time_i = 1'b0;
        async_busy_i = 1'b0;
        ls_request_i = 1'b0;
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        bus(1'b0, PSLT_PERIODIC_START, 32'h0, 1'b1, 32'h0000_0000);
        bus(1'b0, PSLT_LOWSPEED_THRESH, 32'h0, 1'b1, {20'h0, PSLT_LST_RESET});
        bus(1'b0, 8'h48, 32'h0, 1'b0, 32'h0000_0000);
        for (int p = 0; p < 3; p++)
        begin
            ps_val = (p == 0) ? FI_VAL / 14'h000a : 14'h0100 + 14'($random(seed) & 32'h0000_07ff);
            lst_val = (p == 0) ? 12'hfff : ((p == 1) ? 12'h000 : 12'($random(seed)));
            bus(1'b1, PSLT_PERIODIC_START, {18'h0, ps_val}, 1'b1, 32'h0);
            bus(1'b1, PSLT_LOWSPEED_THRESH, {20'h0, lst_val}, 1'b1, 32'h0);
            bus(1'b1, 8'h4c, 32'hffff_ffff, 1'b0, 32'h0);
            bus(1'b0, PSLT_PERIODIC_START, 32'h0, 1'b1, {18'h0, ps_val});
            bus(1'b0, PSLT_LOWSPEED_THRESH, 32'h0, 1'b1, {20'h0, lst_val});
            bus(1'b0, PSLT_BAR_CFG_OFFSET, 32'h0, 1'b0, 32'h0);
            target = p + 1;
            run_en = 1'b1;
            wait (reloads == p + 1 && exp_fr == 14'h0000);
            run_en = 1'b0;
            repeat (3) @(posedge clk_i);
        end
        check(32'(go_cnt), 32'h0000_0001);
        close_out();
    end

endmodule : periodic_start_ls_threshold_tb

`default_nettype wire
